//--- hw/usbu_pkg.sv
// Purpose: Shared constants for the USB to serial bridge core
// Assumes: 125 MHz system clock
// Notes:   Baud divisors are derived from CLK_HZ and the rate table
package usbu_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int          BAUD_N = 29;
  // Standard rates, index 0 upward
  localparam int unsigned BAUD_RATE [BAUD_N] = '{
    300, 600, 1200, 1800, 2400, 4000, 4800, 7200, 9600, 14400, 16000, 19200,
    28800, 38400, 51200, 56000, 57600, 64000, 76800, 115200, 128000, 153600,
    230400, 250000, 256000, 460800, 500000, 576000, 921600};
  localparam logic [4:0]  BAUD_MAX_IDX = 5'h1c;
  localparam logic [4:0]  BAUD_RST_IDX = 5'h08;
  localparam int          HDIV_W       = 18;

  // Character length code: value plus five data bits
  localparam logic [1:0]  BITS5        = 2'h0;
  localparam logic [1:0]  BITS7        = 2'h2;
  localparam logic [1:0]  BITS8        = 2'h3;
  localparam logic [2:0]  LAST_BASE    = 3'h4;

  localparam logic [1:0]  STOP_1       = 2'h0;
  localparam logic [1:0]  STOP_1P5     = 2'h1;
  localparam logic [1:0]  STOP_2       = 2'h2;
  // Half-bit periods minus one
  localparam logic [2:0]  HV_HALF      = 3'h0;
  localparam logic [2:0]  HV_BIT       = 3'h1;
  localparam logic [2:0]  HV_STOP1P5   = 3'h2;
  localparam logic [2:0]  HV_STOP2     = 3'h3;

  localparam logic [2:0]  PAR_NONE     = 3'h0;
  localparam logic [2:0]  PAR_EVEN     = 3'h1;
  localparam logic [2:0]  PAR_ODD      = 3'h2;
  localparam logic [2:0]  PAR_MARK     = 3'h3;
  localparam logic [2:0]  PAR_SPACE    = 3'h4;

  localparam logic [1:0]  FLOW_NONE    = 2'h0;
  localparam logic [1:0]  FLOW_RTS     = 2'h1;
  localparam logic [1:0]  FLOW_DTR     = 2'h2;
  localparam logic [1:0]  FLOW_SW      = 2'h3;
  localparam logic [7:0]  CHAR_XON     = 8'h11;
  localparam logic [7:0]  CHAR_XOFF    = 8'h13;

  localparam logic [7:0]  DEF_PWR_ATTR = 8'h80;
  localparam logic [7:0]  DEF_MAX_PWR  = 8'h32;
  localparam logic [15:0] DEF_RELEASE  = 16'h0100;
  localparam logic [6:0]  DEF_SER_LEN  = 7'h04;
  localparam logic [15:0] SER_MAX      = 16'h003f;
  localparam logic [15:0] DESC_MAX     = 16'h007e;

  localparam logic [2:0]  NV_VENDOR    = 3'h0;
  localparam logic [2:0]  NV_PRODUCT   = 3'h1;
  localparam logic [2:0]  NV_ATTR      = 3'h2;
  localparam logic [2:0]  NV_MAXP      = 3'h3;
  localparam logic [2:0]  NV_REL       = 3'h4;
  localparam logic [2:0]  NV_SER       = 3'h5;
  localparam logic [2:0]  NV_DESC      = 3'h6;
  localparam logic [2:0]  NV_LOCK      = 3'h7;
endpackage

//--- hw/usbu_sync3.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs asynchronous to clk_sys
// Notes:   Output moves only when stages two and three agree
`timescale 1ns/1ps
module usbu_sync3 #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] ff1_r;
  logic [W-1:0] ff2_r;
  logic [W-1:0] ff3_r;
  logic [W-1:0] agree_w;

  assign agree_w = ff2_r ~^ ff3_r;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ff1_r    <= RST_VAL;
      ff2_r    <= RST_VAL;
      ff3_r    <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      ff1_r    <= pin_in;
      ff2_r    <= ff1_r;
      ff3_r    <= ff2_r;
      sync_out <= (agree_w & ff3_r) | (~agree_w & sync_out);
    end
  end
endmodule

//--- hw/usbu_bridge.sv
// Purpose: Serial side, suspend control and descriptor store of the bridge
// Assumes: USB engine reports bus events as one-cycle pulses on clk_sys
// Notes:   Descriptor strings are held as lengths; text lives elsewhere
// How it works
// - USB events arrive from the integrated full-speed transceiver and engine.
// - Host bytes go out the serial port; host commands steer modem lines.
// - Detected bus suspend moves the device into the suspend state.
// - Entering suspend asserts both the high and the low indicators.
// - Asserted means high for one pin and low for the other.
// - After reset both indicators stay asserted until configuration completes.
// - Resume, wake request or bus reset brings the device out of suspend.
// - Leaving suspend deasserts both indicators.
// - Flow control selects request/clear, ready lines, or on/off characters.
// - Characters carry five, six, seven or eight data bits.
// - Parity is none, even, odd, mark or space.
// - Baud divisor comes from the standard rate table, 300 to 921600.
// - The top rate is refused unless characters have seven or eight bits.
// - Descriptor store holds identifiers and strings, defaults until programmed.
// - Default power attributes 80h, max power 32h, release 0100h.
// - Serial string limited to 63 characters, description to 126.
// - Host writes to the descriptor store are accepted over USB.
// - Once locked, any descriptor write is rejected.
`timescale 1ns/1ps
module usbu_bridge #(
  parameter logic [15:0] DEF_VENDOR_ID  = 16'h0f0f, // Arbitrary value
  parameter logic [15:0] DEF_PRODUCT_ID = 16'h0e0e, // Arbitrary value
  parameter logic [6:0]  DEF_DESC_LEN   = 7'h20
) (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        usb_suspend_det,
  input  wire logic        usb_resume_det,
  input  wire logic        usb_bus_reset,
  input  wire logic        usb_configured,
  input  wire logic        wake_req,
  input  wire logic [7:0]  host_tx_data,
  input  wire logic        host_tx_valid,
  output logic             host_tx_ready,
  output logic [7:0]       host_rx_data,
  output logic             host_rx_valid,
  input  wire logic        host_rx_ack,
  input  wire logic        host_rts,
  input  wire logic        host_dtr,
  input  wire logic        cfg_wr,
  input  wire logic [1:0]  cfg_bits,
  input  wire logic [1:0]  cfg_stop,
  input  wire logic [2:0]  cfg_parity,
  input  wire logic [4:0]  cfg_baud_idx,
  input  wire logic [1:0]  cfg_flow,
  output logic             cfg_rej,
  input  wire logic        nv_wr,
  input  wire logic [2:0]  nv_sel,
  input  wire logic [15:0] nv_data,
  output logic             nv_rej,
  output logic             nv_programmed,
  output logic             nv_locked,
  output logic [15:0]      vendor_identifier,
  output logic [15:0]      product_identifier,
  output logic [7:0]       pwr_attr,
  output logic [7:0]       max_power,
  output logic [15:0]      release_num,
  output logic [6:0]       serial_len,
  output logic [6:0]       desc_len,
  input  wire logic        err_clr,
  output logic             parity_err,
  output logic             frame_err,
  output logic             overrun_err,
  output logic             uart_txd,
  input  wire logic        uart_rxd,
  input  wire logic        uart_cts_n,
  output logic             uart_rts_n,
  input  wire logic        uart_dsr_n,
  output logic             uart_dtr_n,
  input  wire logic        uart_dcd_n,
  input  wire logic        uart_ri_n,
  output logic [3:0]       modem_status_n,
  output logic             suspend,
  output logic             suspend_n
);
  typedef enum logic [1:0] {ST_WAIT, ST_RUN, ST_SUSP} usbu_pwr_t;
  typedef enum logic [2:0] {SP_IDLE, SP_START, SP_DATA, SP_PAR, SP_STOP} usbu_ser_t;

  localparam int        HDIV_W_L = usbu_pkg::HDIV_W;
  usbu_pwr_t            pwr_r, pwr_nxt;
  usbu_ser_t            tx_st_r, rx_st_r;
  logic [1:0]           bits_r, stop_r, flow_r;
  logic [2:0]           par_r;
  logic [4:0]           baud_r;
  logic [HDIV_W_L-1:0]  tx_cnt_r, rx_cnt_r;
  logic [2:0]           tx_hv_r, rx_hv_r, tx_bit_r, rx_bit_r;
  logic [7:0]           tx_byte_r, rx_byte_r;
  logic                 xoff_r;
  logic [4:0]           pins_s;

  // Half-bit divisor per table entry, built as constants
  logic [HDIV_W_L-1:0] hdiv_tbl [usbu_pkg::BAUD_N];
  genvar gi;
  generate
    for (gi = 0; gi < usbu_pkg::BAUD_N; gi++) begin : g_div
      assign hdiv_tbl[gi] = HDIV_W_L'(usbu_pkg::CLK_HZ / (2 * usbu_pkg::BAUD_RATE[gi]));
    end
  endgenerate

  usbu_sync3 #(.W(5), .RST_VAL(5'h1f)) u_sync (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .pin_in   ({uart_ri_n, uart_dcd_n, uart_dsr_n, uart_cts_n, uart_rxd}),
    .sync_out (pins_s)
  );
  assign modem_status_n = pins_s[4:1];

  function automatic logic par_of(input logic [7:0] d, input logic [1:0] b,
                                  input logic [2:0] m);
    logic [7:0] md;
    md = d & (8'hff >> (usbu_pkg::BITS8 - b));
    case (m)
      usbu_pkg::PAR_EVEN: par_of = ^md;
      usbu_pkg::PAR_ODD:  par_of = ~^md;
      usbu_pkg::PAR_MARK: par_of = 1'b1;
      default:            par_of = 1'b0;
    endcase
  endfunction

  // Power state: device reset lands in ST_WAIT with both indicators asserted
  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      ST_WAIT: if (usb_configured) pwr_nxt = ST_RUN;
      ST_RUN:  if (usb_suspend_det) pwr_nxt = ST_SUSP;
      ST_SUSP: if (usb_resume_det || wake_req || usb_bus_reset) pwr_nxt = ST_RUN;
      default: pwr_nxt = ST_WAIT;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pwr_r     <= ST_WAIT;
      suspend   <= 1'b1;
      suspend_n <= 1'b0;
    end else begin
      pwr_r     <= pwr_nxt;
      suspend   <= (pwr_nxt != ST_RUN);
      suspend_n <= (pwr_nxt == ST_RUN);
    end
  end

  // Configuration checks
  logic cfg_bad_w;
  assign cfg_bad_w = (cfg_stop == usbu_pkg::STOP_1P5 && cfg_bits != usbu_pkg::BITS5)
                   || (cfg_baud_idx == usbu_pkg::BAUD_MAX_IDX
                       && cfg_bits < usbu_pkg::BITS7)
                   || cfg_baud_idx > usbu_pkg::BAUD_MAX_IDX
                   || cfg_stop > usbu_pkg::STOP_2
                   || cfg_parity > usbu_pkg::PAR_SPACE;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bits_r  <= usbu_pkg::BITS8;
      stop_r  <= usbu_pkg::STOP_1;
      par_r   <= usbu_pkg::PAR_NONE;
      baud_r  <= usbu_pkg::BAUD_RST_IDX;
      flow_r  <= usbu_pkg::FLOW_NONE;
      cfg_rej <= 1'b0;
    end else if (cfg_wr) begin
      cfg_rej <= cfg_bad_w;
      if (!cfg_bad_w) begin
        bits_r <= cfg_bits;
        stop_r <= cfg_stop;
        par_r  <= cfg_parity;
        baud_r <= cfg_baud_idx;
        flow_r <= cfg_flow;
      end
    end
  end

  // Descriptor store
  logic nv_bad_w;
  assign nv_bad_w = nv_locked
                  || (nv_sel == usbu_pkg::NV_SER && nv_data > usbu_pkg::SER_MAX)
                  || (nv_sel == usbu_pkg::NV_DESC && nv_data > usbu_pkg::DESC_MAX);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      vendor_identifier  <= DEF_VENDOR_ID;
      product_identifier <= DEF_PRODUCT_ID;
      pwr_attr           <= usbu_pkg::DEF_PWR_ATTR;
      max_power          <= usbu_pkg::DEF_MAX_PWR;
      release_num        <= usbu_pkg::DEF_RELEASE;
      serial_len         <= usbu_pkg::DEF_SER_LEN;
      desc_len           <= DEF_DESC_LEN;
      nv_programmed      <= 1'b0;
      nv_locked          <= 1'b0;
      nv_rej             <= 1'b0;
    end else if (nv_wr) begin
      nv_rej <= nv_bad_w;
      if (!nv_bad_w) begin
        nv_programmed <= 1'b1;
        case (nv_sel)
          usbu_pkg::NV_VENDOR:  vendor_identifier  <= nv_data;
          usbu_pkg::NV_PRODUCT: product_identifier <= nv_data;
          usbu_pkg::NV_ATTR: pwr_attr           <= nv_data[7:0];
          usbu_pkg::NV_MAXP: max_power          <= nv_data[7:0];
          usbu_pkg::NV_REL:  release_num        <= nv_data;
          usbu_pkg::NV_SER:  serial_len         <= nv_data[6:0];
          usbu_pkg::NV_DESC: desc_len           <= nv_data[6:0];
          default:           nv_locked          <= 1'b1;
        endcase
      end
    end
  end

  // Shared decode for both serial directions
  logic [HDIV_W_L-1:0] hdiv_w;
  logic [2:0]          last_bit_w, stop_hv_w;
  logic                tx_ok_w, tx_take_w, tx_tick_w, rx_tick_w;
  assign hdiv_w     = hdiv_tbl[baud_r] - HDIV_W_L'(1);
  assign last_bit_w = usbu_pkg::LAST_BASE + 3'(bits_r);
  assign stop_hv_w  = (stop_r == usbu_pkg::STOP_1)   ? usbu_pkg::HV_BIT :
                      (stop_r == usbu_pkg::STOP_1P5) ? usbu_pkg::HV_STOP1P5 :
                                                       usbu_pkg::HV_STOP2;
  // Flow gate only stops new characters; one already started always completes
  assign tx_ok_w    = (pwr_r == ST_RUN)
                    && !(flow_r == usbu_pkg::FLOW_RTS && pins_s[1])
                    && !(flow_r == usbu_pkg::FLOW_DTR && pins_s[2])
                    && !(flow_r == usbu_pkg::FLOW_SW && xoff_r);
  assign tx_take_w  = host_tx_valid && host_tx_ready;
  assign tx_tick_w  = (tx_cnt_r == '0);
  assign rx_tick_w  = (rx_cnt_r == '0);

  // Transmitter
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tx_st_r       <= SP_IDLE;
      tx_cnt_r      <= '0;
      tx_hv_r       <= '0;
      tx_bit_r      <= '0;
      tx_byte_r     <= '0;
      uart_txd      <= 1'b1;
      host_tx_ready <= 1'b0;
    end else begin
      host_tx_ready <= (tx_st_r == SP_IDLE) && tx_ok_w && !tx_take_w;
      tx_cnt_r      <= (tx_st_r == SP_IDLE || tx_tick_w) ? hdiv_w : tx_cnt_r - HDIV_W_L'(1);
      if (tx_take_w) begin
        tx_byte_r <= host_tx_data;
        tx_st_r   <= SP_START;
        tx_hv_r   <= usbu_pkg::HV_BIT;
        uart_txd  <= 1'b0;
      end else if (tx_st_r != SP_IDLE && tx_tick_w) begin
        if (tx_hv_r != '0) begin
          tx_hv_r <= tx_hv_r - 3'h1;
        end else begin
          tx_hv_r <= usbu_pkg::HV_BIT;
          case (tx_st_r)
            SP_START: begin
              tx_st_r  <= SP_DATA;
              tx_bit_r <= '0;
              uart_txd <= tx_byte_r[0];
            end
            SP_DATA: begin
              if (tx_bit_r != last_bit_w) begin
                tx_bit_r <= tx_bit_r + 3'h1;
                uart_txd <= tx_byte_r[tx_bit_r + 3'h1];
              end else if (par_r != usbu_pkg::PAR_NONE) begin
                tx_st_r  <= SP_PAR;
                uart_txd <= par_of(tx_byte_r, bits_r, par_r);
              end else begin
                tx_st_r  <= SP_STOP;
                tx_hv_r  <= stop_hv_w;
                uart_txd <= 1'b1;
              end
            end
            SP_PAR: begin
              tx_st_r  <= SP_STOP;
              tx_hv_r  <= stop_hv_w;
              uart_txd <= 1'b1;
            end
            default: begin
              tx_st_r  <= SP_IDLE;
              uart_txd <= 1'b1;
            end
          endcase
        end
      end
    end
  end

  // Receiver samples mid-bit; only the first stop bit is checked
  logic rx_end_w, rx_sw_char_w, rx_del_w;
  assign rx_end_w     = (rx_st_r == SP_STOP) && rx_tick_w && (rx_hv_r == '0);
  assign rx_sw_char_w = (flow_r == usbu_pkg::FLOW_SW)
                      && (rx_byte_r == usbu_pkg::CHAR_XON || rx_byte_r == usbu_pkg::CHAR_XOFF);
  assign rx_del_w     = rx_end_w && !rx_sw_char_w;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rx_st_r    <= SP_IDLE;
      rx_cnt_r   <= '0;
      rx_hv_r    <= '0;
      rx_bit_r   <= '0;
      rx_byte_r  <= '0;
      parity_err <= 1'b0;
    end else begin
      rx_cnt_r   <= (rx_st_r == SP_IDLE || rx_tick_w) ? hdiv_w : rx_cnt_r - HDIV_W_L'(1);
      parity_err <= (parity_err && !err_clr)
                  || (rx_st_r == SP_PAR && rx_tick_w && rx_hv_r == '0
                      && pins_s[0] != par_of(rx_byte_r, bits_r, par_r));
      if (rx_st_r == SP_IDLE) begin
        if (!pins_s[0]) begin
          rx_st_r   <= SP_START;
          rx_hv_r   <= usbu_pkg::HV_HALF;
          rx_byte_r <= '0;
        end
      end else if (rx_tick_w) begin
        if (rx_hv_r != '0) begin
          rx_hv_r <= rx_hv_r - 3'h1;
        end else begin
          rx_hv_r <= usbu_pkg::HV_BIT;
          case (rx_st_r)
            SP_START: begin
              rx_st_r  <= pins_s[0] ? SP_IDLE : SP_DATA;
              rx_bit_r <= '0;
            end
            SP_DATA: begin
              rx_byte_r[rx_bit_r] <= pins_s[0];
              rx_bit_r            <= rx_bit_r + 3'h1;
              if (rx_bit_r == last_bit_w) begin
                rx_st_r <= (par_r != usbu_pkg::PAR_NONE) ? SP_PAR : SP_STOP;
              end
            end
            SP_PAR:  rx_st_r <= SP_STOP;
            default: rx_st_r <= SP_IDLE;
          endcase
        end
      end
    end
  end

  // Delivery, sticky errors (set beats clear) and handshake outputs
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      host_rx_data  <= '0;
      host_rx_valid <= 1'b0;
      frame_err     <= 1'b0;
      overrun_err   <= 1'b0;
      xoff_r        <= 1'b0;
      uart_rts_n    <= 1'b1;
      uart_dtr_n    <= 1'b1;
    end else begin
      host_rx_valid <= rx_del_w || (host_rx_valid && !host_rx_ack);
      if (rx_del_w && !(host_rx_valid && !host_rx_ack)) begin
        host_rx_data <= rx_byte_r;
      end
      frame_err   <= (frame_err && !err_clr) || (rx_end_w && !pins_s[0]);
      overrun_err <= (overrun_err && !err_clr) || (rx_del_w && host_rx_valid && !host_rx_ack);
      if (rx_end_w && rx_sw_char_w) begin
        xoff_r <= (rx_byte_r == usbu_pkg::CHAR_XOFF);
      end else if (flow_r != usbu_pkg::FLOW_SW) begin
        xoff_r <= 1'b0;
      end
      // Hardware modes: line asserted while the receive holding slot is free
      uart_rts_n <= (flow_r == usbu_pkg::FLOW_RTS) ? host_rx_valid : !host_rts;
      uart_dtr_n <= (flow_r == usbu_pkg::FLOW_DTR) ? host_rx_valid : !host_dtr;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  property p_pair;  suspend == !suspend_n; endproperty
  a_pair: assert property (p_pair) else $error("suspend pins disagree");
  property p_enter; (pwr_r == ST_RUN && usb_suspend_det) |=> suspend && !suspend_n; endproperty
  a_enter: assert property (p_enter) else $error("suspend not entered");
  property p_exit;
    (pwr_r == ST_SUSP && (usb_resume_det || usb_bus_reset || wake_req)) |=> !suspend && suspend_n;
  endproperty
  a_exit: assert property (p_exit) else $error("suspend not left");
  property p_wait;  (pwr_r == ST_WAIT && !usb_configured) |=> suspend; endproperty
  a_wait: assert property (p_wait) else $error("indicator dropped early");
  property p_top;
    (cfg_wr && cfg_baud_idx == usbu_pkg::BAUD_MAX_IDX && cfg_bits < usbu_pkg::BITS7)
      |=> cfg_rej && $stable(baud_r);
  endproperty
  a_top: assert property (p_top) else $error("top rate accepted");
  property p_s15;
    (cfg_wr && cfg_stop == usbu_pkg::STOP_1P5 && cfg_bits != usbu_pkg::BITS5)
      |=> cfg_rej && $stable(stop_r);
  endproperty
  a_s15: assert property (p_s15) else $error("1.5 stop accepted");
  property p_lock;  (nv_locked && nv_wr) |=> nv_rej && $stable(vendor_identifier); endproperty
  a_lock: assert property (p_lock) else $error("locked store written");
  property p_xoff;
    (rx_end_w && flow_r == usbu_pkg::FLOW_SW && rx_byte_r == usbu_pkg::CHAR_XOFF)
      |=> xoff_r ##1 !host_tx_ready [*2];
  endproperty
  a_xoff: assert property (p_xoff) else $error("transmit-off ignored");
  property p_cts;
    (flow_r == usbu_pkg::FLOW_RTS && pins_s[1] && tx_st_r == SP_IDLE) |=> !host_tx_ready;
  endproperty
  a_cts: assert property (p_cts) else $error("sent against clear line");

  c_susp: cover property (pwr_r == ST_SUSP ##[1:50] pwr_r == ST_RUN);
  c_frame: cover property (tx_take_w ##[1:300] tx_st_r == SP_DATA);
  c_rx: cover property (rx_del_w);
  c_xoff: cover property (rx_end_w && rx_sw_char_w);
endmodule

//--- verification/usbu_peer.sv
// Purpose: Serial peer model facing the bridge, 8N1 frames only
// Assumes: bit_cyc is the bridge bit time in clk_sys cycles
// Notes:   Line idles high between frames, as a real mark state
`timescale 1ns/1ps
module usbu_peer (
  input  wire logic        clk_sys,
  input  wire logic        txd,
  input  wire logic [31:0] bit_cyc,
  output logic             rxd,
  output logic [7:0]       got,
  output int               got_cnt
);
  initial begin
    rxd = 1'b1;
    got = 8'h00;
    got_cnt = 0;
  end
  // Centre sampling, so edge placement errors show as wrong bits
  always begin
    @(negedge txd);
    repeat (bit_cyc / 2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge clk_sys);
      got[i] = txd;
    end
    repeat (bit_cyc) @(posedge clk_sys);
    got_cnt++;
  end
  // Also carries the on/off flow characters
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_sys);
      rxd <= f[i];
      repeat (bit_cyc - 1) @(posedge clk_sys);
    end
  endtask
endmodule

//--- verification/tb.sv
// Purpose: Self-checking bench for the bridge core
// Assumes: Peer speaks 8N1 at the top rate set here
// Notes:   Random fields come from a fixed-seed xorshift
`timescale 1ns/1ps
module tb;
  logic        clk_sys, arst_n, host_tx_valid, cfg_wr, nv_wr, rxd;
  logic        usb_configured, usb_suspend_det, usb_resume_det, usb_bus_reset, wake_req;
  logic        host_rx_ack, host_tx_ready, host_rx_valid, cfg_rej, nv_rej, nv_programmed;
  logic        nv_locked, uart_txd, uart_rts_n, uart_dtr_n, suspend, suspend_n, err_clr, overrun_err;
  logic [6:0]  ev;
  logic [7:0]  host_tx_data, host_rx_data, pwr_attr, max_power, got;
  logic [1:0]  cfg_bits, cfg_stop, cfg_flow;
  logic [2:0]  cfg_parity, nv_sel;
  logic [4:0]  cfg_baud_idx;
  logic [15:0] nv_data, vendor_identifier, product_identifier, release_num;
  logic [6:0]  serial_len, desc_len;
  logic [3:0]  modem_status_n, mdm;
  logic [31:0] seed, rv;
  int          err_count, n_compared, bit_cyc, got_cnt;
  logic [11:0] cc [4] = '{12'h41c, 12'h41c, 12'h89c, 12'hc60};
  assign {err_clr, host_rx_ack, wake_req, usb_bus_reset, usb_resume_det, usb_suspend_det,
          usb_configured} = ev;
  usbu_bridge i_usbu_bridge (.clk_sys, .arst_n, .usb_suspend_det, .usb_resume_det,
    .usb_bus_reset, .usb_configured, .wake_req, .host_tx_data, .host_tx_valid,
    .host_tx_ready, .host_rx_data, .host_rx_valid, .host_rx_ack, .host_rts(rv[4]),
    .host_dtr(rv[5]), .cfg_wr, .cfg_bits, .cfg_stop, .cfg_parity, .cfg_baud_idx, .cfg_flow,
    .cfg_rej, .nv_wr, .nv_sel, .nv_data, .nv_rej, .nv_programmed, .nv_locked,
    .vendor_identifier, .product_identifier, .pwr_attr, .max_power, .release_num,
    .serial_len, .desc_len, .err_clr, .parity_err(), .frame_err(), .overrun_err,
    .uart_txd, .uart_rxd(rxd), .uart_cts_n(mdm[0]), .uart_rts_n, .uart_dsr_n(mdm[1]),
    .uart_dtr_n, .uart_dcd_n(mdm[2]), .uart_ri_n(mdm[3]), .modem_status_n, .suspend,
    .suspend_n);
  usbu_peer i_usbu_peer (.clk_sys, .txd(uart_txd), .bit_cyc, .rxd, .got, .got_cnt);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic exp_rej(input logic [11:0] f);
    return f[9:8] == 2'h3 || (f[9:8] == 2'h1 && f[11:10] != 2'h0) || f[7:5] > 3'h4
      || f[4:0] > 5'h1c || (f[4:0] == 5'h1c && f[11:10] < 2'h2);
  endfunction
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic pulse(input int k);
    @(posedge clk_sys);
    ev <= 7'h01 << k;
    @(posedge clk_sys);
    ev <= 7'h00;
    #1;
  endtask
  task automatic cfg(input logic [11:0] f, input logic [1:0] fl);
    @(posedge clk_sys);
    {cfg_bits, cfg_stop, cfg_parity, cfg_baud_idx} <= f;
    cfg_flow <= fl;
    cfg_wr <= 1'b1;
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
    #1;
    chk("cfg_rej", exp_rej(f), cfg_rej);
  endtask
  task automatic nv(input logic [2:0] s, input logic [15:0] d, input logic r);
    @(posedge clk_sys);
    nv_sel <= s;
    nv_data <= d;
    nv_wr <= 1'b1;
    @(posedge clk_sys);
    nv_wr <= 1'b0;
    #1;
    chk("nv_rej", r, nv_rej);
  endtask
  task automatic tx(input logic [7:0] b);
    int n, c;
    logic r;
    c = got_cnt;
    @(posedge clk_sys);
    host_tx_data <= b;
    host_tx_valid <= 1'b1;
    n = 0;
    do begin
      @(negedge clk_sys);
      r = host_tx_ready;
      n++;
      @(posedge clk_sys);
    end while (r !== 1'b1 && n < 5000);
    host_tx_valid <= 1'b0;
    for (n = 0; got_cnt == c && n < 5000; n++) @(posedge clk_sys);
    chk("serial byte", b, got);
  endtask
  task automatic rx(input logic [7:0] b);
    int n;
    i_usbu_peer.send(b);
    for (n = 0; host_rx_valid !== 1'b1 && n < 50; n++) @(posedge clk_sys);
    #1;
    chk("host_rx_data", b, host_rx_data);
    pulse(5);
  endtask
  // Pins settle first; then ready must stay low the whole wait
  task automatic blk();
    logic h;
    h = 1'b0;
    repeat (8) @(posedge clk_sys);
    host_tx_valid <= 1'b1;
    repeat (300) @(negedge clk_sys) h = h | host_tx_ready;
    @(posedge clk_sys);
    host_tx_valid <= 1'b0;
    chk("host_tx_ready", 1'b0, h);
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_count++;
    results();
  end
  initial begin
    seed = 32'h0000ddbf;
    {ev, arst_n, host_tx_valid, cfg_wr, nv_wr, host_tx_data, nv_sel, nv_data} = '0;
    {cfg_bits, cfg_stop, cfg_parity, cfg_baud_idx, cfg_flow, mdm, rv} = '0;
    err_count = 0;
    n_compared = 0;
    bit_cyc = 2 * (usbu_pkg::CLK_HZ / (2 * usbu_pkg::BAUD_RATE[28]));
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("suspend", 1'b1, suspend);
    chk("suspend_n", 1'b0, suspend_n);
    chk("pwr_attr", 8'h80, pwr_attr);
    chk("max_power", 8'h32, max_power);
    chk("release_num", 16'h0100, release_num);
    chk("vendor_identifier", 16'h0f0f, vendor_identifier);
    pulse(0);
    chk("suspend", 1'b0, suspend);
    for (int k = 2; k < 5; k++) begin
      pulse(1);
      chk("suspend", 1'b1, suspend);
      chk("suspend_n", 1'b0, suspend_n);
      pulse(k);
      chk("suspend", 1'b0, suspend);
      chk("suspend_n", 1'b1, suspend_n);
    end
    $display("test power done");
    foreach (cc[i]) cfg(cc[i], 2'h0);
    repeat (24) cfg(12'(rnd()), 2'h0);
    cfg(12'hc1c, 2'h0);
    rv = rnd();
    mdm <= rv[3:0];
    repeat (8) @(posedge clk_sys);
    #1;
    chk("modem_status_n", mdm, modem_status_n);
    chk("uart_rts_n", !rv[4], uart_rts_n);
    chk("uart_dtr_n", !rv[5], uart_dtr_n);
    mdm <= 4'h0;
    $display("test config done");
    tx(8'h00);
    tx(8'hff);
    repeat (2) tx(8'(rnd()));
    repeat (2) rx(8'(rnd()));
    i_usbu_peer.send(8'h55);
    i_usbu_peer.send(8'haa);
    chk("overrun_err", 1'b1, overrun_err);
    chk("host_rx_data", 8'h55, host_rx_data);
    pulse(5);
    pulse(6);
    chk("overrun_err", 1'b0, overrun_err);
    for (int m = 1; m < 3; m++) begin
      cfg(12'hc1c, 2'(m));
      mdm <= 4'(m);
      blk();
      chk("flow line", 1'b0, m == 1 ? uart_rts_n : uart_dtr_n);
      mdm <= 4'h0;
      tx(8'(rnd()));
    end
    cfg(12'hc1c, 2'h3);
    i_usbu_peer.send(usbu_pkg::CHAR_XOFF);
    blk();
    chk("host_rx_valid", 1'b0, host_rx_valid);
    i_usbu_peer.send(usbu_pkg::CHAR_XON);
    tx(8'(rnd()));
    $display("test serial done");
    rv = rnd();
    nv(usbu_pkg::NV_VENDOR, rv[15:0], 1'b0);
    chk("vendor_identifier", rv[15:0], vendor_identifier);
    chk("nv_programmed", 1'b1, nv_programmed);
    nv(usbu_pkg::NV_SER, 16'h003f, 1'b0);
    nv(usbu_pkg::NV_SER, 16'h0040, 1'b1);
    chk("serial_len", 7'h3f, serial_len);
    nv(usbu_pkg::NV_DESC, 16'h007e, 1'b0);
    nv(usbu_pkg::NV_DESC, 16'h007f, 1'b1);
    chk("desc_len", 7'h7e, desc_len);
    nv(usbu_pkg::NV_LOCK, 16'h0001, 1'b0);
    nv(usbu_pkg::NV_PRODUCT, 16'h1234, 1'b1);
    chk("product_identifier", 16'h0e0e, product_identifier);
    chk("nv_locked", 1'b1, nv_locked);
    $display("test store done");
    pulse(1);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("suspend", 1'b1, suspend);
    pulse(0);
    chk("suspend_n", 1'b1, suspend_n);
    $display("test reset done");
    results();
  end
endmodule
